// [pwm_pkg.sv]
package pwm_pkg;
	// register byte offsets
	localparam logic [7:0] off_duty_low = 8'h00;
	localparam logic [7:0] off_duty_high = 8'h04;
	localparam logic [7:0] off_module_control = 8'h08;
	localparam logic [7:0] off_period_limit = 8'h0c;
	localparam logic [7:0] off_timer_control = 8'h10;
	localparam logic [7:0] off_period_timer = 8'h14;
	localparam logic [7:0] off_gpio_dir = 8'h18;
	localparam logic [7:0] off_gpio_latch = 8'h1c;
	localparam logic [7:0] off_pin_status = 8'h20;
	// field positions
	localparam int duty_lsb_pos = 4;
	localparam int mode_pos = 0;
	localparam int timer_on_pos = 2;
	localparam int prescale_pos = 0;
	localparam int pin_bit = 2;
	// reset values
	localparam logic [7:0] rst_module_control = 8'h00;
	localparam logic [7:0] rst_period_limit = 8'hff;
	localparam logic [7:0] rst_timer_control = 8'h00;
	localparam logic [7:0] rst_gpio_dir = 8'hff;
	localparam logic [7:0] rst_gpio_latch = 8'h00;
	localparam logic [7:0] rst_duty = 8'h00;
	localparam logic [7:0] control_mask = 8'h3f;
	localparam logic [7:0] timer_control_mask = 8'h7f;
	// mode field: waveform mode is 11xx
	localparam logic [1:0] mode_waveform_top = 2'h3;
	// timing: one timer tick per instruction cycle of 4 oscillator periods at prescale 1:1
	localparam int osc_per_cycle = 4;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// [pwm_tick_if.sv]
`timescale 1ns/1ps
interface pwm_tick_if;
	logic timer_on;
	logic [1:0] prescale_sel;
	logic tick;
	logic [1:0] sub_bits;
	modport divider
	(
		input timer_on,
		input prescale_sel,
		output tick,
		output sub_bits
	);
	modport core
	(
		output timer_on,
		output prescale_sel,
		input tick,
		input sub_bits
	);
endinterface

// [pwm_prescaler.sv]
`timescale 1ns/1ps
module pwm_prescaler
(
	input wire logic core_clk,
	input wire logic nrst,
	pwm_tick_if.divider tk
);
	logic [1:0] q_r;
	logic [1:0] q_nxt;
	logic [3:0] pre_r;
	logic [3:0] pre_nxt;
	logic q_wrap;
	logic [3:0] pre_top;

	// prescale 1, 4, 16; codes 2 and 3 both give 16
	always_comb
	begin
		q_wrap = (q_r == 2'h3);
		unique case (tk.prescale_sel)
			2'h0: pre_top = 4'h0;
			2'h1: pre_top = 4'h3;
			default: pre_top = 4'hf;
		endcase
		q_nxt = q_r + 2'h1;
		pre_nxt = pre_r;
		if (!tk.timer_on)
			pre_nxt = 4'h0;
		else if (q_wrap)
			pre_nxt = (pre_r >= pre_top) ? 4'h0 : pre_r + 4'h1;
		tk.tick = tk.timer_on && q_wrap && (pre_r >= pre_top);
		// low extension bits: quarter-cycle count at 1:1, prescaler bits otherwise
		unique case (tk.prescale_sel)
			2'h0: tk.sub_bits = q_r;
			2'h1: tk.sub_bits = pre_r[1:0];
			default: tk.sub_bits = pre_r[3:2];
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q_r <= 2'h0;
			pre_r <= 4'h0;
		end
		else
		begin
			q_r <= q_nxt;
			pre_r <= pre_nxt;
		end
	end
endmodule

// [pwm_core.sv]
// Behaviour
// - drive a pulse-width waveform on the output pin with up to ten-bit duty
// - writing zero to module control forces the waveform latch low, not gpio
// - period is (limit+1) times four oscillator periods times prescale
// - timer equal to limit clears on next increment; boundary events then
// - in waveform mode pin goes high one clock after each boundary unless duty is zero
// - at each boundary in waveform mode the duty value is copied into the shadow register
// - duty is low register as msbs and control bits 5:4 as lsbs
// - duty writes reach shadow only at boundary; shadow read-only in waveform mode
// - pin clears when shadow matches timer extended by two low bits
// - duty longer than the period never clears the pin
`timescale 1ns/1ps
module pwm_core
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic waveform_out_pin_in,
	output logic waveform_out_pin_out,
	output logic waveform_out_pin_oe
);
	pwm_tick_if tk();

	logic [7:0] duty_low_r, duty_low_nxt;
	logic [7:0] duty_high_r, duty_high_nxt;
	logic [1:0] duty_latch_r, duty_latch_nxt;
	logic [7:0] control_r, control_nxt;
	logic [7:0] period_limit_r, period_limit_nxt;
	logic [7:0] timer_control_r, timer_control_nxt;
	logic [7:0] period_timer_r, period_timer_nxt;
	logic [7:0] gpio_dir_r, gpio_dir_nxt;
	logic [7:0] gpio_latch_r, gpio_latch_nxt;
	logic wave_r, wave_nxt;
	logic set_r, set_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic aw_have_r, aw_have_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic w_have_r, w_have_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic pin_s1_r, pin_s2_r;
	logic do_write;
	logic wave_mode;
	logic boundary;
	logic [9:0] duty_next_val;
	logic [7:0] wbyte;
	logic [31:0] rd_word;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= pwm_pkg::off_pin_status) && (a[1:0] == 2'h0);
	endfunction

	pwm_prescaler u_pre
	(
		.core_clk(core_clk),
		.nrst(nrst),
		.tk(tk)
	);

	assign tk.timer_on = timer_control_r[pwm_pkg::timer_on_pos];
	assign tk.prescale_sel = timer_control_r[pwm_pkg::prescale_pos +: 2];
	assign wave_mode = (control_r[pwm_pkg::mode_pos + 2 +: 2] == pwm_pkg::mode_waveform_top);
	assign boundary = tk.tick && (period_timer_r == period_limit_r);
	assign duty_next_val = {duty_low_r, control_r[pwm_pkg::duty_lsb_pos +: 2]};

	assign awready = !aw_have_r && !bvalid_r;
	assign wready = !w_have_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
	// pin shared with gpio latch; direction bit 2 low makes it an output
	assign waveform_out_pin_oe = !gpio_dir_r[pwm_pkg::pin_bit];
	assign waveform_out_pin_out = wave_mode ? wave_r : gpio_latch_r[pwm_pkg::pin_bit];

	// bus channel capture
	always_comb
	begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (awvalid && awready)
		begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = awaddr;
		end
		if (wvalid && wready)
		begin
			w_have_nxt = 1'b1;
			w_data_nxt = wdata;
			w_strb_nxt = wstrb;
		end
		do_write = aw_have_r && w_have_r;
		if (do_write)
		begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped(aw_addr_r) ? pwm_pkg::resp_okay : pwm_pkg::resp_slverr;
		end
		else if (bvalid_r && bready)
			bvalid_nxt = 1'b0;
		wbyte = w_data_r[7:0];
	end

	// read path
	always_comb
	begin
		unique case (araddr)
			pwm_pkg::off_duty_low: rd_word = {24'h0, duty_low_r};
			pwm_pkg::off_duty_high: rd_word = {24'h0, duty_high_r};
			pwm_pkg::off_module_control: rd_word = {24'h0, control_r};
			pwm_pkg::off_period_limit: rd_word = {24'h0, period_limit_r};
			pwm_pkg::off_timer_control: rd_word = {24'h0, timer_control_r};
			pwm_pkg::off_period_timer: rd_word = {24'h0, period_timer_r};
			pwm_pkg::off_gpio_dir: rd_word = {24'h0, gpio_dir_r};
			pwm_pkg::off_gpio_latch: rd_word = {24'h0, gpio_latch_r};
			pwm_pkg::off_pin_status: rd_word = {29'h0, duty_latch_r, pin_s2_r};
			default: rd_word = 32'h0;
		endcase
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (arvalid && arready)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rresp_nxt = mapped(araddr) ? pwm_pkg::resp_okay : pwm_pkg::resp_slverr;
		end
		else if (rvalid_r && rready)
			rvalid_nxt = 1'b0;
	end

	// register file, timer and waveform
	always_comb
	begin
		duty_low_nxt = duty_low_r;
		duty_high_nxt = duty_high_r;
		duty_latch_nxt = duty_latch_r;
		control_nxt = control_r;
		period_limit_nxt = period_limit_r;
		timer_control_nxt = timer_control_r;
		period_timer_nxt = period_timer_r;
		gpio_dir_nxt = gpio_dir_r;
		gpio_latch_nxt = gpio_latch_r;
		wave_nxt = wave_r;
		set_nxt = 1'b0;
		if (tk.tick)
			period_timer_nxt = boundary ? 8'h00 : period_timer_r + 8'h01;
		if (wave_mode)
		begin
			// clear on match of shadow and timer with two low bits; beyond period never matches
			if ({duty_high_r, duty_latch_r} == {period_timer_r, tk.sub_bits})
				wave_nxt = 1'b0;
			// set one clock after the boundary so rise and fall share the same register delay
			if (set_r)
				wave_nxt = ({duty_high_r, duty_latch_r} != 10'h0);
			if (boundary)
			begin
				duty_high_nxt = duty_next_val[9:2];
				duty_latch_nxt = duty_next_val[1:0];
				set_nxt = 1'b1;
			end
		end
		if (do_write && w_strb_r[0])
		begin
			unique case (aw_addr_r)
				pwm_pkg::off_duty_low: duty_low_nxt = wbyte;
				pwm_pkg::off_duty_high: if (!wave_mode) duty_high_nxt = wbyte;
				pwm_pkg::off_module_control:
				begin
					control_nxt = wbyte & pwm_pkg::control_mask;
					if (wbyte == 8'h00)
						wave_nxt = 1'b0;
				end
				pwm_pkg::off_period_limit: period_limit_nxt = wbyte;
				pwm_pkg::off_timer_control: timer_control_nxt = wbyte & pwm_pkg::timer_control_mask;
				pwm_pkg::off_period_timer: period_timer_nxt = wbyte;
				pwm_pkg::off_gpio_dir: gpio_dir_nxt = wbyte;
				pwm_pkg::off_gpio_latch: gpio_latch_nxt = wbyte;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			duty_low_r <= pwm_pkg::rst_duty;
			duty_high_r <= pwm_pkg::rst_duty;
			duty_latch_r <= 2'h0;
			control_r <= pwm_pkg::rst_module_control;
			period_limit_r <= pwm_pkg::rst_period_limit;
			timer_control_r <= pwm_pkg::rst_timer_control;
			period_timer_r <= 8'h00;
			gpio_dir_r <= pwm_pkg::rst_gpio_dir;
			gpio_latch_r <= pwm_pkg::rst_gpio_latch;
			wave_r <= 1'b0;
			set_r <= 1'b0;
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r <= 1'b0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rresp_r <= 2'h0;
			rdata_r <= 32'h0;
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end
		else
		begin
			duty_low_r <= duty_low_nxt;
			duty_high_r <= duty_high_nxt;
			duty_latch_r <= duty_latch_nxt;
			control_r <= control_nxt;
			period_limit_r <= period_limit_nxt;
			timer_control_r <= timer_control_nxt;
			period_timer_r <= period_timer_nxt;
			gpio_dir_r <= gpio_dir_nxt;
			gpio_latch_r <= gpio_latch_nxt;
			wave_r <= wave_nxt;
			set_r <= set_nxt;
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			pin_s1_r <= waveform_out_pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end
endmodule

// [pwm_checker.sv]
`timescale 1ns/1ps
module pwm_checker
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic waveform_out_pin_oe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_b_hold; bvalid && !bready |=> bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_r_wide; rvalid |-> rdata[31:8] == 24'h0; endproperty
	a_r_wide: assert property (p_r_wide) else $error("read data upper bits set");
	property p_b_late; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
	a_b_late: assert property (p_b_late) else $error("write response late");
	property p_r_next; arvalid && arready |=> rvalid; endproperty
	a_r_next: assert property (p_r_next) else $error("read response late");
	property p_r_err; arvalid && arready && araddr == 8'h24 |=> rresp == pwm_pkg::resp_slverr && rdata == 32'h0; endproperty
	a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
	property p_ar_busy; rvalid |-> !arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
	property p_dir;
		logic v;
		(awvalid && awready && wvalid && wready && awaddr == pwm_pkg::off_gpio_dir, v = wdata[2]) |-> ##3 waveform_out_pin_oe == !v;
	endproperty
	a_dir: assert property (p_dir) else $error("pin enable does not follow direction");
	c_wr: cover property (bvalid && bready);
	c_rd: cover property (rvalid && rready);
	c_err: cover property (rvalid && rresp == pwm_pkg::resp_slverr);
endmodule
bind pwm_core pwm_checker i_chk (.core_clk(core_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .waveform_out_pin_oe(waveform_out_pin_oe));

// [pwm_load.sv]
`timescale 1ns/1ps
module pwm_load
(
	input wire logic core_clk,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_level,
	output logic [15:0] n_rise,
	output logic [15:0] n_fall,
	output logic [15:0] hi_len,
	output logic [15:0] per_len
);
	logic prev = 1'b0;
	logic [15:0] hi_cnt = 16'h0;
	logic [15:0] per_cnt = 16'h0;
	logic [15:0] rise_cnt = 16'h0;
	logic [15:0] fall_cnt = 16'h0;
	// load pulls the pin down when nobody drives it
	assign pin_level = pin_oe ? pin_out : 1'b0;
	assign n_rise = rise_cnt;
	assign n_fall = fall_cnt;
	// measures high time and rise-to-rise time in clocks
	always @(posedge core_clk)
	begin
		prev <= pin_level;
		hi_cnt <= pin_level ? hi_cnt + 16'h1 : 16'h0;
		per_cnt <= (pin_level && !prev) ? 16'h1 : per_cnt + 16'h1;
		if (pin_level && !prev)
		begin
			rise_cnt <= rise_cnt + 16'h1;
			per_len <= per_cnt;
		end
		if (!pin_level && prev)
		begin
			fall_cnt <= fall_cnt + 16'h1;
			hi_len <= hi_cnt;
		end
	end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_t;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_in;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd_v;
	logic [15:0] n_rise, n_fall, hi_len, per_len, k;
	int n_mismatch = 0;
	int checked = 0;
	row_t rows[8] = '{
		'{pwm_pkg::off_duty_low, 8'h5a, 8'h5a, 2'h0},
		'{pwm_pkg::off_module_control, 8'hc3, 8'h03, 2'h0},
		'{pwm_pkg::off_timer_control, 8'h80, 8'h00, 2'h0},
		'{pwm_pkg::off_period_limit, 8'h03, 8'h03, 2'h0},
		'{pwm_pkg::off_gpio_latch, 8'h04, 8'h04, 2'h0},
		'{pwm_pkg::off_duty_high, 8'h77, 8'h77, 2'h0},
		'{8'h24, 8'h11, 8'h00, 2'h2},
		'{8'h02, 8'h11, 8'h00, 2'h2}};
	pwm_core i_dut
	(
		.core_clk(core_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .waveform_out_pin_in(pin_in), .waveform_out_pin_out(pin_out), .waveform_out_pin_oe(pin_oe)
	);
	pwm_load i_load
	(
		.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in), .n_rise(n_rise),
		.n_fall(n_fall), .hi_len(hi_len), .per_len(per_len)
	);
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		bready <= 1'b0;
		resp = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		rready <= 1'b0;
		rd_v = rdata;
		resp = rresp;
	endtask
	task automatic results;
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		forever #20 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		results();
	end
	initial
	begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			chk("write resp", {30'h0, rows[i].r}, {30'h0, resp});
			rd(rows[i].a);
			chk("read data", {24'h0, rows[i].e}, rd_v);
			chk("read resp", {30'h0, rows[i].r}, {30'h0, resp});
		end
		chk("pin enable", 32'h0, {31'h0, pin_oe});
		wr(pwm_pkg::off_gpio_dir, 8'hfb);
		repeat (2) @(posedge core_clk);
		chk("pin driven", 32'h1, {31'h0, pin_in});
		wr(pwm_pkg::off_gpio_latch, 8'hfb);
		wr(pwm_pkg::off_duty_low, 8'h01);
		wr(pwm_pkg::off_module_control, 8'h2c);
		wr(pwm_pkg::off_timer_control, 8'h04);
		repeat (100) @(posedge core_clk);
		chk("period 1:1", 32'd16, {16'h0, per_len});
		chk("high 1:1", 32'd6, {16'h0, hi_len});
		wr(pwm_pkg::off_timer_control, 8'h05);
		repeat (200) @(posedge core_clk);
		chk("period 1:4", 32'd64, {16'h0, per_len});
		chk("high 1:4", 32'd24, {16'h0, hi_len});
		k = n_rise;
		while (n_rise == k) @(posedge core_clk);
		wr(pwm_pkg::off_duty_low, 8'h02);
		wr(pwm_pkg::off_duty_high, 8'h55);
		rd(pwm_pkg::off_duty_high);
		chk("shadow held", 32'h01, rd_v);
		repeat (150) @(posedge core_clk);
		rd(pwm_pkg::off_duty_high);
		chk("shadow loaded", 32'h02, rd_v);
		chk("high new duty", 32'd40, {16'h0, hi_len});
		wr(pwm_pkg::off_duty_low, 8'h10);
		repeat (200) @(posedge core_clk);
		k = n_fall;
		repeat (200) @(posedge core_clk);
		chk("no clear", {16'h0, k}, {16'h0, n_fall});
		chk("pin held high", 32'h1, {31'h0, pin_in});
		wr(pwm_pkg::off_timer_control, 8'h01);
		wr(pwm_pkg::off_module_control, 8'h00);
		@(posedge core_clk);
		chk("latch cleared", 32'h0, {31'h0, pin_out});
		wr(pwm_pkg::off_module_control, 8'h2c);
		chk("wave latch low", 32'h0, {31'h0, pin_out});
		rd(pwm_pkg::off_gpio_latch);
		chk("gpio latch kept", 32'hfb, rd_v);
		wr(pwm_pkg::off_duty_low, 8'h00);
		wr(pwm_pkg::off_module_control, 8'h0c);
		wr(pwm_pkg::off_timer_control, 8'h05);
		repeat (200) @(posedge core_clk);
		k = n_rise;
		repeat (200) @(posedge core_clk);
		chk("zero duty rises", {16'h0, k}, {16'h0, n_rise});
		chk("zero duty pin", 32'h0, {31'h0, pin_in});
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		chk("enable after reset", 32'h0, {31'h0, pin_oe});
		rd(pwm_pkg::off_module_control);
		chk("control reset", 32'h00, rd_v);
		rd(pwm_pkg::off_period_limit);
		chk("limit reset", 32'hff, rd_v);
		rd(pwm_pkg::off_gpio_dir);
		chk("direction reset", 32'hff, rd_v);
		results();
	end
endmodule
